// *** verilog/rtcti_core.sv ***
// real-time clock core: clock/calendar bytes, alarm, divider, flags, APB slave
// assumes osc_in and on_battery are asynchronous pins; APB master on clk
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
module rtcti_core
    import rtcti_pkg::*;
#(
    // last divider count; lower values only shorten simulation, taps above it stand still
    parameter logic [14:0] DIV_END = DIV_LAST
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [8:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        osc_in,
    input  wire logic        on_battery,
    output logic             square_wave_out,
    output logic             irq_n_o,
    output logic             irq_oe_o
);
    // synchronisers
    logic osc_s1_r, osc_s2_r, osc_s3_r;
    logic bat_s1_r, bat_s2_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
            bat_s1_r <= 1'b0;
            bat_s2_r <= 1'b0;
        end else begin
            osc_s1_r <= osc_in;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
            bat_s1_r <= on_battery;
            bat_s2_r <= bat_s1_r;
        end
    end

    // conversion helpers
    function automatic logic [7:0] to_bin(input logic [7:0] v, input logic is_bin);
        return is_bin ? v : (({4'h0, v[7:4]} * 8'd10) + {4'h0, v[3:0]});
    endfunction
    function automatic logic [7:0] from_bin(input logic [7:0] n, input logic is_bin);
        logic [7:0] tens;
        logic [7:0] ones;
        tens = n / 8'd10;
        ones = n % 8'd10;
        return is_bin ? n : {tens[3:0], ones[3:0]};
    endfunction
    function automatic logic [7:0] hr_dec(input logic [7:0] v, input logic is_bin,
                                          input logic h24);
        logic [7:0] h;
        h = to_bin({1'b0, v[6:0]}, is_bin);
        if (h24) begin
            return to_bin(v, is_bin);
        end
        if (h == 8'd12) begin
            h = 8'd0;
        end
        return v[7] ? h + 8'd12 : h;
    endfunction
    function automatic logic [7:0] hr_enc(input logic [7:0] h, input logic is_bin,
                                          input logic h24);
        logic [7:0] h12;
        logic [7:0] e;
        h12 = (h >= 8'd12) ? h - 8'd12 : h;
        if (h12 == 8'd0) begin
            h12 = 8'd12;
        end
        e = from_bin(h12, is_bin);
        if (h24) begin
            return from_bin(h, is_bin);
        end
        return {h >= 8'd12, e[6:0]};
    endfunction
    function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
        case (mon)
            8'd2:                      return (yr[1:0] == 2'b00) ? 8'd29 : 8'd28;
            8'd4, 8'd6, 8'd9, 8'd11:   return 8'd30;
            default:                   return 8'd31;
        endcase
    endfunction

    // divider and tap selector
    logic [14:0] div_r, div_nxt;
    logic        tap_prev_r, tap_prev_nxt;
    logic        sqw_r, sqw_nxt;
    logic [3:0]  rate_r;
    logic [3:0]  tap_idx;
    logic        osc_edge, tick, tap_sel, pf_evt;
    always_comb begin
        osc_edge = osc_s2_r & ~osc_s3_r;
        tick     = osc_edge && (div_r == DIV_END);
        div_nxt  = tick ? 15'h0 : (osc_edge ? div_r + 15'h1 : div_r);
        // divider keeps running whatever the oscillator field holds
        case (rate_r)
            4'h1:    tap_idx = 4'h6;
            4'h2:    tap_idx = 4'h7;
            default: tap_idx = 4'(rate_r - 4'h2);
        endcase
        tap_sel      = (rate_r != 4'h0) && div_r[tap_idx];
        pf_evt       = tap_sel & ~tap_prev_r;
        tap_prev_nxt = tap_sel;
        sqw_nxt      = tap_sel;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_r      <= 15'h0;
            tap_prev_r <= 1'b0;
            sqw_r      <= 1'b0;
        end else begin
            div_r      <= div_nxt;
            tap_prev_r <= tap_prev_nxt;
            sqw_r      <= sqw_nxt;
        end
    end

    // update cycle sequencer
    rtcti_upd_t upd_r, upd_nxt;
    logic [3:0] ucnt_r, ucnt_nxt;
    always_comb begin
        upd_nxt  = upd_r;
        ucnt_nxt = ucnt_r;
        unique case (upd_r)
            UPD_IDLE: begin
                if (tick) begin
                    upd_nxt  = UPD_BUSY;
                    ucnt_nxt = 4'h0;
                end
            end
            UPD_BUSY: begin
                ucnt_nxt = ucnt_r + 4'h1;
                if (ucnt_r == 4'(UPD_CYCLES - 1)) begin
                    upd_nxt = UPD_END;
                end
            end
            UPD_END: upd_nxt = UPD_IDLE;
            default: upd_nxt = UPD_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            upd_r  <= UPD_IDLE;
            ucnt_r <= 4'h0;
        end else begin
            upd_r  <= upd_nxt;
            ucnt_r <= ucnt_nxt;
        end
    end

    // apb front end: no wait state; read data is registered in the setup phase so it comes from a flop
    logic [6:0]  idx;
    logic        setup, acc, wr_en, rd_c;
    logic [7:0]  rd_byte;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [7:0]  ram_r [0:RAM_BYTES-1];
    logic [7:0]  cb_r [0:9];
    logic [7:0]  cb_nxt [0:9];
    logic [2:0]  osc_r, osc_nxt;
    logic [3:0]  rate_nxt;
    logic [7:0]  ctlb_r, ctlb_nxt;
    logic [7:4]  flags_r, flags_nxt;
    logic [6:0]  ram_idx;
    always_comb begin
        idx     = paddr[8:2];
        ram_idx = 7'(idx - IDX_RAM_BASE);
        setup   = psel & ~penable;
        acc     = psel & penable & pready_r;
        // writes are locked out while on battery; alarm path is not gated
        wr_en   = acc & pwrite & ~pslverr_r & ~bat_s2_r;
        rd_c    = acc & ~pwrite & ~pslverr_r & (idx == IDX_STAT_C);
        if (idx < IDX_CTRL_A) begin
            rd_byte = cb_r[idx[3:0]];
        end else if (idx == IDX_CTRL_A) begin
            rd_byte = {upd_r != UPD_IDLE, osc_r, rate_r};
        end else if (idx == IDX_CTRL_B) begin
            rd_byte = ctlb_r;
        end else if (idx == IDX_STAT_C) begin
            rd_byte = {flags_r, 4'h0};
        end else if (idx == IDX_STAT_D) begin
            rd_byte = STATD_VAL;
        end else begin
            rd_byte = ram_r[ram_idx];
        end
        pready_nxt  = setup;
        pslverr_nxt = setup & (paddr[1:0] != 2'b00);
        prdata_nxt  = (setup & ~pwrite) ? {24'h0, rd_byte} : prdata_r;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end
    // battery-backed storage, no reset by design
    always_ff @(posedge clk) begin
        if (wr_en && idx >= IDX_RAM_BASE) begin
            ram_r[ram_idx] <= pwdata[7:0];
        end
    end

    // time keeping and alarm
    logic       is_bin, h24, update_transfer_inhibit;
    logic [7:0] sec, mnt, hr, wd, dom, mon, yr;
    logic [7:0] t_s, t_h, t_m;
    logic       alarm_match;
    always_comb begin
        is_bin = ctlb_r[B_DF];
        h24    = ctlb_r[B_HF];
        update_transfer_inhibit    = ctlb_r[B_UTI];
        sec    = to_bin(cb_r[IDX_SECONDS_COUNT[3:0]], is_bin);
        mnt    = to_bin(cb_r[IDX_MINUTES_COUNT[3:0]], is_bin);
        hr     = hr_dec(cb_r[IDX_HOURS_COUNT[3:0]], is_bin, h24);
        wd     = to_bin(cb_r[IDX_WEEKDAY_COUNT[3:0]], is_bin);
        dom    = to_bin(cb_r[IDX_MONTHDAY_COUNT[3:0]], is_bin);
        mon    = to_bin(cb_r[IDX_MONTH_COUNT[3:0]], is_bin);
        yr     = to_bin(cb_r[IDX_YEAR_COUNT[3:0]], is_bin);
        sec    = sec + 8'd1;
        if (sec >= 8'd60) begin
            sec = 8'd0;
            mnt = mnt + 8'd1;
            if (mnt >= 8'd60) begin
                mnt = 8'd0;
                hr  = hr + 8'd1;
                if (hr >= 8'd24) begin
                    hr  = 8'd0;
                    wd  = (wd >= 8'd7) ? 8'd1 : wd + 8'd1;
                    dom = dom + 8'd1;
                    if (dom > days_in(mon, yr)) begin
                        dom = 8'd1;
                        mon = mon + 8'd1;
                        if (mon > 8'd12) begin
                            mon = 8'd1;
                            yr  = (yr >= 8'd99) ? 8'd0 : yr + 8'd1;
                        end
                    end
                end
            end
        end
        for (int i = 0; i < 10; i++) begin
            cb_nxt[i] = cb_r[i];
        end
        if (upd_r == UPD_END && !update_transfer_inhibit) begin
            cb_nxt[IDX_SECONDS_COUNT[3:0]]  = from_bin(sec, is_bin);
            cb_nxt[IDX_MINUTES_COUNT[3:0]]  = from_bin(mnt, is_bin);
            cb_nxt[IDX_HOURS_COUNT[3:0]]    = hr_enc(hr, is_bin, h24);
            cb_nxt[IDX_WEEKDAY_COUNT[3:0]]  = from_bin(wd, is_bin);
            cb_nxt[IDX_MONTHDAY_COUNT[3:0]] = from_bin(dom, is_bin);
            cb_nxt[IDX_MONTH_COUNT[3:0]]    = from_bin(mon, is_bin);
            cb_nxt[IDX_YEAR_COUNT[3:0]]     = from_bin(yr, is_bin);
        end
        // alarm is checked against the bytes as they stand after this update
        t_s = cb_nxt[IDX_SECONDS_COUNT[3:0]];
        t_m = cb_nxt[IDX_MINUTES_COUNT[3:0]];
        t_h = cb_nxt[IDX_HOURS_COUNT[3:0]];
        alarm_match = (cb_r[IDX_SECONDS_ALARM[3:0]][7:6] == 2'b11
                       || cb_r[IDX_SECONDS_ALARM[3:0]] == t_s)
                   && (cb_r[IDX_MINUTES_ALARM[3:0]][7:6] == 2'b11
                       || cb_r[IDX_MINUTES_ALARM[3:0]] == t_m)
                   && (cb_r[IDX_HOURS_ALARM[3:0]][7:6] == 2'b11
                       || cb_r[IDX_HOURS_ALARM[3:0]] == t_h);
        // a write in the last update cycle wins over the transfer
        if (wr_en && idx < IDX_CTRL_A) begin
            cb_nxt[idx[3:0]] = pwdata[7:0];
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 10; i++) begin
                cb_r[i] <= 8'h00;
            end
            cb_r[IDX_WEEKDAY_COUNT[3:0]]  <= 8'h01;
            cb_r[IDX_MONTHDAY_COUNT[3:0]] <= 8'h01;
            cb_r[IDX_MONTH_COUNT[3:0]]    <= 8'h01;
        end else begin
            for (int i = 0; i < 10; i++) begin
                cb_r[i] <= cb_nxt[i];
            end
        end
    end

    // control registers
    always_comb begin
        osc_nxt  = osc_r;
        rate_nxt = rate_r;
        ctlb_nxt = ctlb_r;
        if (wr_en && idx == IDX_CTRL_A) begin
            osc_nxt  = pwdata[6:4];
            rate_nxt = pwdata[3:0];
        end
        if (wr_en && idx == IDX_CTRL_B) begin
            ctlb_nxt = {pwdata[7:4], 1'b0, pwdata[2:1], 1'b0};
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_r  <= OSC_RST;
            rate_r <= RATE_RST;
            ctlb_r <= CTRLB_RST;
        end else begin
            osc_r  <= osc_nxt;
            rate_r <= rate_nxt;
            ctlb_r <= ctlb_nxt;
        end
    end

    // event flags and interrupt pin
    logic       af_evt, uf_evt, irq_req;
    logic [7:4] c_clr;
    logic       irq_oe_r, irq_oe_nxt, irq_n_r, irq_n_nxt;
    always_comb begin
        af_evt  = (upd_r == UPD_END) && alarm_match;
        uf_evt  = (upd_r == UPD_END);
        irq_req = (pf_evt & ctlb_r[B_PIE]) | (af_evt & ctlb_r[B_AIE])
                | (uf_evt & ctlb_r[B_UIE] & ~update_transfer_inhibit);
        // only the bits the reader saw are cleared, so a late event survives
        c_clr   = rd_c ? prdata_r[7:4] : 4'h0;
        flags_nxt[C_PF]   = (flags_r[C_PF] & ~c_clr[C_PF]) | pf_evt;
        flags_nxt[C_AF]   = (flags_r[C_AF] & ~c_clr[C_AF]) | af_evt;
        flags_nxt[C_UF]   = (flags_r[C_UF] & ~c_clr[C_UF]) | uf_evt;
        flags_nxt[C_IRQF] = (flags_r[C_IRQF] & ~c_clr[C_IRQF]) | irq_req;
        irq_oe_nxt = flags_nxt[C_IRQF];
        irq_n_nxt  = ~flags_nxt[C_IRQF];
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_r  <= 4'h0;
            irq_oe_r <= 1'b0;
            irq_n_r  <= 1'b1;
        end else begin
            flags_r  <= flags_nxt;
            irq_oe_r <= irq_oe_nxt;
            irq_n_r  <= irq_n_nxt;
        end
    end

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign square_wave_out = sqw_r;
    assign irq_n_o         = irq_n_r;
    assign irq_oe_o        = irq_oe_r;

    // checks
    default clocking cb_chk @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_upd_run;
        (upd_r == UPD_BUSY) [*4] ##1 (upd_r == UPD_END);
    endsequence
    a_uip_window: assert property ((tick && upd_r == UPD_IDLE) |=> s_upd_run ##1
        (upd_r == UPD_IDLE)) else $error("update cycle length wrong");
    a_uf_each_update: assert property ((upd_r == UPD_END) |=> flags_r[C_UF])
        else $error("update-ended flag not set");
    a_uf_irq_gate: assert property ((upd_r == UPD_END && ctlb_r[B_UIE] && !update_transfer_inhibit)
        |=> flags_r[C_IRQF] && irq_oe_o && !irq_n_o) else $error("update irq missing");
    a_pf_flag_set: assert property (pf_evt |=> flags_r[C_PF])
        else $error("periodic flag lost");
    a_summary_cause: assert property ($rose(flags_r[C_IRQF]) |-> $past(irq_req))
        else $error("summary flag without enabled event");
    a_c_read_clear: assert property ((rd_c && !pf_evt && upd_r != UPD_END)
        |=> (flags_r & $past(c_clr)) == 4'h0) else $error("status read did not clear");
    a_inhibit_hold: assert property ((upd_r == UPD_END && update_transfer_inhibit && !wr_en)
        |=> $stable(cb_r[IDX_SECONDS_COUNT[3:0]])) else $error("transfer while inhibited");
    a_alarm_flag: assert property (af_evt |=> flags_r[C_AF])
        else $error("alarm match did not set flag");
    a_sqw_off: assert property ((rate_r == 4'h0) |=> !square_wave_out)
        else $error("square wave active with rate zero");
    a_irq_pin: assert property (irq_oe_o == flags_r[C_IRQF] && irq_n_o == !irq_oe_o)
        else $error("interrupt pin disagrees with summary flag");
endmodule // rtcti_core

// *** verilog/rtcti_pkg.sv ***
// constants, register map and state types for the real-time clock core
// assumes a 250 MHz system clock and a 32.768 kHz oscillator on a pin
// Function
// - 14 clock/control bytes plus 114 storage bytes
// - one bit selects BCD or binary bytes
// - one bit selects 12 or 24 hour
// - inhibit bit blocks counter-to-byte transfers
// - first update after inhibit refreshes all bytes
// - 12h: hours 1-12, bit 7 marks afternoon
// - 24h: hours 0 to 23
// - weekday counts 1 to 7, Sunday is 1
// - divide oscillator down to 1 Hz tick
// - divider taps selected feed square wave, periodic
// - rate field picks tap, zero disables
// - oscillator field 011 leaves periodic timing alone
// - each event has own enable bit
// - flag always set, request only when enabled
// - summary flag set on any request
// - reading status clears flags, releases interrupt
// - update compares time with alarm bytes
// - alarm keeps working on battery power
// - alarm byte with top bits 11 ignored
// - update-ended flag set every update
// - update request needs enable and no inhibit
// - status A shows update in progress
package rtcti_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned UPD_TIME_NS   = 16;
    localparam int unsigned UPD_CYCLES    = (UPD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // byte indices; bus byte address is four times the index
    localparam logic [6:0] IDX_SECONDS_COUNT  = 7'h00;
    localparam logic [6:0] IDX_SECONDS_ALARM  = 7'h01;
    localparam logic [6:0] IDX_MINUTES_COUNT  = 7'h02;
    localparam logic [6:0] IDX_MINUTES_ALARM  = 7'h03;
    localparam logic [6:0] IDX_HOURS_COUNT    = 7'h04;
    localparam logic [6:0] IDX_HOURS_ALARM    = 7'h05;
    localparam logic [6:0] IDX_WEEKDAY_COUNT  = 7'h06;
    localparam logic [6:0] IDX_MONTHDAY_COUNT = 7'h07;
    localparam logic [6:0] IDX_MONTH_COUNT    = 7'h08;
    localparam logic [6:0] IDX_YEAR_COUNT     = 7'h09;
    localparam logic [6:0] IDX_CTRL_A         = 7'h0A;
    localparam logic [6:0] IDX_CTRL_B         = 7'h0B;
    localparam logic [6:0] IDX_STAT_C         = 7'h0C;
    localparam logic [6:0] IDX_STAT_D         = 7'h0D;
    localparam logic [6:0] IDX_RAM_BASE       = 7'h0E;
    localparam int unsigned RAM_BYTES         = 114;
    // control B field positions
    localparam int unsigned B_UTI = 7;
    localparam int unsigned B_PIE = 6;
    localparam int unsigned B_AIE = 5;
    localparam int unsigned B_UIE = 4;
    localparam int unsigned B_DF  = 2;
    localparam int unsigned B_HF  = 1;
    // status C field positions
    localparam int unsigned C_IRQF = 7;
    localparam int unsigned C_PF   = 6;
    localparam int unsigned C_AF   = 5;
    localparam int unsigned C_UF   = 4;
    // values after reset
    localparam logic [2:0] OSC_RST   = 3'h2;
    localparam logic [3:0] RATE_RST  = 4'h0;
    localparam logic [7:0] CTRLB_RST = 8'h02;
    localparam logic [7:0] STATD_VAL = 8'h80;
    localparam logic [14:0] DIV_LAST = 15'h7FFF;
    typedef enum logic [2:0] {
        UPD_IDLE = 3'b001,
        UPD_BUSY = 3'b010,
        UPD_END  = 3'b100
    } rtcti_upd_t;
endpackage

// *** tb/rtcti_host.sv ***
// host-side partner: apb master tasks and the oscillator pin
// assumes the core answers every access with pready; osc_in stands still unless osc_run
`timescale 1ns/1ns
module rtcti_host (
    // clock and oscillator control
    input  wire logic        clk,
    input  wire logic        osc_run,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [8:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // oscillator pin
    output logic             osc_in
);
    logic [1:0] ph_r;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 9'h000;
        pwdata = 32'h00000000;
        osc_in = 1'b0;
        ph_r = 2'h0;
    end

    // eight clk per oscillator period, slower than the two-clk period the core's synchroniser could follow
    always @(posedge clk) begin
        if (osc_run) begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h3) osc_in <= ~osc_in;
        end
    end

    task automatic xfer(input logic wr, input logic [8:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep looking valid
        paddr <= ~a;
        pwdata <= ~{24'h000000, d};
    endtask
endmodule // rtcti_host

// *** tb/testbench.sv ***
// self-checking bench for the real-time clock core against a byte-array model
// assumes rtcti_host as apb master and oscillator; divider cut to 2048 osc edges per update
`timescale 1ns/1ns
module testbench
    import rtcti_pkg::*;
;
    logic        clk;
    logic        arst_n;
    logic        osc_run;
    logic        on_battery;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [8:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc_in;
    logic        square_wave_out;
    logic        irq_n_o;
    logic        irq_oe_o;
    logic [7:0]  rd;
    logic        err;
    int          errors;
    int          total_checks;
    int          cyc;
    int          t0;
    int          a;
    int          mem [128];
    logic [7:0]  tset [10] = '{8'h3B, 8'h00, 8'h3B, 8'hC0, 8'h8B, 8'hC0, 8'h07, 8'h1F,
                               8'h0C, 8'h63};

    rtcti_core #(.DIV_END(15'h07FF)) rtcti_core_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_in(osc_in), .on_battery(on_battery),
        .square_wave_out(square_wave_out), .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o));
    rtcti_host rtcti_host_inst (.clk(clk), .osc_run(osc_run), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_in(osc_in));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic close_out();
        $display("errors=%0d total_checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // three shortened updates need about 50k cycles, so the ceiling sits above that
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors = errors + 1;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input int idx, input logic [7:0] d);
        rtcti_host_inst.xfer(1'b1, 9'(idx * 4), d, rd, err);
        if (on_battery !== 1'b1 && idx != 12 && idx != 13)
            mem[idx] = (idx == 10) ? (d & 8'h7F) : (idx == 11) ? (d & 8'hF6) : d;
    endtask

    task automatic rdc(input int idx);
        rtcti_host_inst.xfer(1'b0, 9'(idx * 4), 8'h00, rd, err);
        chk({err, rd}, {1'b0, 8'(mem[idx])});
        if (idx == 12) mem[12] = 0;
    endtask

    task automatic wait_rise();
        while (square_wave_out !== 1'b0) @(posedge clk);
        while (square_wave_out !== 1'b1) @(posedge clk);
    endtask

    initial begin
        errors = 0;
        total_checks = 0;
        cyc = 0;
        arst_n = 1'b0;
        osc_run = 1'b0;
        on_battery = 1'b0;
        void'($urandom(56));
        for (int i = 0; i < 128; i++) mem[i] = (i >= 6 && i <= 8) ? 1 : 0;
        mem[10] = 'h20;
        mem[11] = 'h02;
        mem[13] = 'h80;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 14; i++) rdc(i);
        // read-only and ignored places, then storage bytes
        wr(10, 8'hFF);
        rdc(10);
        wr(11, 8'hFF);
        rdc(11);
        wr(11, 8'h02);
        wr(12, 8'hFF);
        wr(13, 8'h00);
        rdc(12);
        rdc(13);
        wr(20, 8'h5A);
        for (int i = 0; i < 8; i++) begin
            a = 14 + $urandom % 114;
            wr(a, 8'($urandom));
            rdc(a);
        end
        // periodic source enabled; osc field 011 on rates 1 to 8
        wr(11, 8'h42);
        osc_run <= 1'b1;
        for (int r = 1; r <= 8; r++) begin
            wr(10, 8'(8'h30 | r));
            wait_rise();
            t0 = cyc;
            wait_rise();
            chk(cyc - t0, (r < 3 ? 64 << r : 1 << (r - 1)) * 8);
        end
        wr(10, 8'h20);
        mem[12] = 'hC0;
        chk({irq_oe_o, irq_n_o}, 2'b10);
        rtcti_host_inst.xfer(1'b0, 9'h031, 8'h00, rd, err);
        chk(err, 1'b1);
        rdc(12);
        @(posedge clk);
        chk({irq_oe_o, irq_n_o, square_wave_out}, 3'b010);
        // periodic flag with its enable off
        wr(11, 8'h02);
        wr(10, 8'h23);
        wait_rise();
        wait_rise();
        wr(10, 8'h20);
        mem[12] = 'h40;
        chk(irq_oe_o, 1'b0);
        rdc(12);
        // set time the documented way, then one update on battery
        wr(11, 8'h84);
        for (int i = 0; i < 10; i++) wr(i, tset[i]);
        wr(11, 8'h34);
        on_battery <= 1'b1;
        wr(20, 8'hA5);
        while (irq_oe_o !== 1'b1) @(posedge clk);
        repeat (8) @(posedge clk);
        mem[0] = 0;
        mem[2] = 0;
        mem[4] = 'h0C;
        mem[6] = 1;
        mem[7] = 1;
        mem[8] = 1;
        mem[9] = 0;
        mem[12] = 'hB0;
        for (int i = 0; i < 14; i++) rdc(i);
        rdc(20);
        @(posedge clk);
        chk({irq_oe_o, irq_n_o}, 2'b01);
        // inhibited update: flags still set, bytes held, no update request
        on_battery <= 1'b0;
        wr(11, 8'h96);
        do rtcti_host_inst.xfer(1'b0, 9'h030, 8'h00, rd, err); while (rd == 8'h00);
        chk({irq_oe_o, rd}, 9'h030);
        for (int i = 0; i < 10; i++) rdc(i);
        // BCD 24h, eve of a leap day
        tset = '{8'h59, 8'h00, 8'h59, 8'hC0, 8'h23, 8'h00, 8'h07, 8'h28, 8'h02, 8'h04};
        wr(11, 8'h82);
        for (int i = 0; i < 10; i++) wr(i, tset[i]);
        wr(11, 8'h32);
        do rtcti_host_inst.xfer(1'b0, 9'h028, 8'h00, rd, err); while (rd == 8'h20);
        chk(rd, 8'hA0);
        while (irq_oe_o !== 1'b1) @(posedge clk);
        mem[0] = 0;
        mem[2] = 0;
        mem[4] = 0;
        mem[6] = 1;
        mem[7] = 'h29;
        mem[12] = 'hB0;
        for (int i = 0; i < 14; i++) rdc(i);
        close_out();
    end
endmodule // testbench
